// *** src/fcb_pkg.sv ***
package fcb_pkg;

  // ----------------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [11:0] ADDR_BUFCTL   = 12'h0000;
  localparam logic [11:0] ADDR_PGMCTL   = 12'h0004;
  localparam logic [11:0] ADDR_PGMADDR  = 12'h0008;
  localparam logic [11:0] ADDR_PGMDATA  = 12'h000C;
  localparam logic [11:0] ADDR_ERACTL   = 12'h0010;
  localparam logic [11:0] ADDR_ERASTAT  = 12'h0014;
  localparam logic [11:0] ADDR_IRQRAW   = 12'h0018;
  localparam logic [11:0] ADDR_IRQEN    = 12'h001C;
  localparam logic [11:0] ADDR_IRQMSK   = 12'h0020;
  localparam logic [11:0] ADDR_IRQCLR   = 12'h0024;
  localparam logic [11:0] ADDR_OPSTAT   = 12'h0028;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int BUF_B0_DATA   = 0;
  localparam int BUF_B0_INSTR  = 1;
  localparam int BUF_B1_DATA   = 2;
  localparam int BUF_B1_INSTR  = 3;
  localparam int PGM_EN_BIT    = 0;
  localparam int PGM_MODE_BIT  = 1;
  localparam int ERA_START_BIT = 0;
  localparam int ERA_INFO_BIT  = 1;

  localparam int IRQ_PGM_ERR     = 0;
  localparam int IRQ_BENCH       = 1;
  localparam int IRQ_ERASE_DONE  = 2;
  localparam int IRQ_BURST_PGM   = 3;
  localparam int IRQ_WORD_PGM    = 4;
  localparam int IRQ_POST_VFY    = 5;
  localparam int IRQ_PRE_VFY     = 6;
  localparam int IRQ_BURST_RDCMP = 7;
  localparam int IRQ_NUM         = 8;

  // ----------------------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------------------
  localparam int SECTOR_BITS    = 12;
  localparam int COLLATE_BITS   = 128;
  localparam int COLLATE_WORDS  = COLLATE_BITS / 32;
  localparam logic [3:0] BUF_RESET = 4'h0;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;

  typedef enum logic {WMODE_IMMEDIATE, WMODE_COLLATED} fcb_wmode_t;

  typedef struct packed {
    logic          valid;
    logic          wide;
    logic [31:0]   addr;
    logic [127:0]  data;
  } fcb_pgm_req_t;

  typedef struct packed {
    logic          valid;
    logic          info;
    logic [31:0]   addr;
  } fcb_erase_req_t;

  typedef struct packed {
    logic          pgmErr;
    logic          bench;
    logic          eraseDone;
    logic          eraseFail;
    logic          burstPgmDone;
    logic          wordPgmDone;
    logic          postVerifyFail;
    logic          preVerifyFail;
    logic          burstRdCmpDone;
  } fcb_events_t;

endpackage

// *** src/fcb_ctrl.sv ***
`timescale 1ns/100ps
module fcb_ctrl
  import fcb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [ADDR_W-1:0]       paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // flash core requests
  output fcb_pkg::fcb_pgm_req_t        pgmReq,
  output fcb_pkg::fcb_erase_req_t      eraseReq,
  output logic      [3:0]              readBufEn,
  // flash core events
  input  wire fcb_pkg::fcb_events_t    coreEvt,
  input  wire logic                    coreBusy,
  // interrupt
  output logic                         irq
);
  import fcb_pkg::*;

  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  if (ADDR_W < 6 || ADDR_W > 32) begin
    $error("fcb_ctrl: ADDR_W out of range");
  end
  if (COLLATE_WORDS != 4) begin
    $error("fcb_ctrl: collation counter holds four words");
  end
  if (IRQ_NUM != 8) begin
    $error("fcb_ctrl: flag logic serves eight sources");
  end
  if (SECTOR_BITS < 2 || SECTOR_BITS > 31) begin
    $error("fcb_ctrl: sector size out of range");
  end

  // ----------------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  logic              acc;
  logic              wrAcc;
  logic              rdAcc;
  logic              mapped;
  assign acc   = psel && penable;
  assign wrAcc = acc && pwrite;
  assign rdAcc = acc && !pwrite;
  assign mapped = hit(paddr, ADDR_BUFCTL) || hit(paddr, ADDR_PGMCTL) || hit(paddr, ADDR_PGMADDR)
               || hit(paddr, ADDR_PGMDATA) || hit(paddr, ADDR_ERACTL) || hit(paddr, ADDR_ERASTAT)
               || hit(paddr, ADDR_IRQRAW) || hit(paddr, ADDR_IRQEN) || hit(paddr, ADDR_IRQMSK)
               || hit(paddr, ADDR_IRQCLR) || hit(paddr, ADDR_OPSTAT);

  // ----------------------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------------------
  logic [3:0]        bufEn_q,   bufEn_d;
  logic              pgmEn_q,   pgmEn_d;
  fcb_wmode_t        wMode_q,   wMode_d;
  logic [31:0]       pgmAddr_q, pgmAddr_d;
  logic [7:0]        irqEn_q,   irqEn_d;

  always_comb begin
    bufEn_d   = bufEn_q;
    pgmEn_d   = pgmEn_q;
    wMode_d   = wMode_q;
    pgmAddr_d = pgmAddr_q;
    irqEn_d   = irqEn_q;
    if (wrAcc && hit(paddr, ADDR_BUFCTL)) begin
      bufEn_d = pwdata[3:0];
    end
    if (wrAcc && hit(paddr, ADDR_PGMCTL)) begin
      pgmEn_d = pwdata[PGM_EN_BIT];
      wMode_d = fcb_wmode_t'(pwdata[PGM_MODE_BIT]);
    end
    if (wrAcc && hit(paddr, ADDR_PGMADDR)) begin
      pgmAddr_d = pwdata;
    end
    if (wrAcc && hit(paddr, ADDR_IRQEN)) begin
      irqEn_d = pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bufEn_q   <= BUF_RESET;
      pgmEn_q   <= 1'b0;
      wMode_q   <= WMODE_IMMEDIATE;
      pgmAddr_q <= 32'h0000_0000;
      irqEn_q   <= IRQ_EN_RESET;
    end else begin
      bufEn_q   <= bufEn_d;
      pgmEn_q   <= pgmEn_d;
      wMode_q   <= wMode_d;
      pgmAddr_q <= pgmAddr_d;
      irqEn_q   <= irqEn_d;
    end
  end

  // ----------------------------------------------------------------------------
  // program path
  // ----------------------------------------------------------------------------
  logic [127:0]      coll_q,    coll_d;
  logic [1:0]        collCnt_q, collCnt_d;
  fcb_pgm_req_t      pgm_q,     pgm_d;
  logic              pgmWrite;
  assign pgmWrite = wrAcc && hit(paddr, ADDR_PGMDATA);

  always_comb begin
    coll_d    = coll_q;
    collCnt_d = collCnt_q;
    pgm_d     = '0;
    // partial collation dropped while disabled
    if (!pgmEn_q) begin
      collCnt_d = 2'd0;
    end else if (pgmWrite) begin
      if (wMode_q == WMODE_IMMEDIATE) begin
        pgm_d.valid = 1'b1;
        pgm_d.wide  = 1'b0;
        pgm_d.addr  = pgmAddr_q;
        pgm_d.data  = {96'h0, pwdata};
      end else begin
        coll_d[collCnt_q*32 +: 32] = pwdata;
        collCnt_d = collCnt_q + 2'd1;
        if (collCnt_q == 2'(COLLATE_WORDS - 1)) begin
          pgm_d.valid = 1'b1;
          pgm_d.wide  = 1'b1;
          pgm_d.addr  = {pgmAddr_q[31:4], 4'h0};
          pgm_d.data  = coll_d;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coll_q    <= 128'h0;
      collCnt_q <= 2'd0;
      pgm_q     <= '0;
    end else begin
      coll_q    <= coll_d;
      collCnt_q <= collCnt_d;
      pgm_q     <= pgm_d;
    end
  end

  // ----------------------------------------------------------------------------
  // erase path
  // ----------------------------------------------------------------------------
  fcb_erase_req_t    era_q,     era_d;
  logic              eraBusy_q, eraBusy_d;
  logic [1:0]        eraStat_q, eraStat_d;

  always_comb begin
    era_d     = '0;
    eraBusy_d = eraBusy_q;
    eraStat_d = eraStat_q;
    // start ignored while an erase runs
    if (wrAcc && hit(paddr, ADDR_ERACTL) && pwdata[ERA_START_BIT] && !eraBusy_q) begin
      era_d.valid = 1'b1;
      era_d.info  = pwdata[ERA_INFO_BIT];
      era_d.addr  = {pgmAddr_q[31:SECTOR_BITS], {SECTOR_BITS{1'b0}}};
      eraBusy_d   = 1'b1;
      eraStat_d   = 2'b00;
    end else if (eraBusy_q && (coreEvt.eraseDone || coreEvt.eraseFail)) begin
      eraBusy_d = 1'b0;
      eraStat_d = {coreEvt.eraseFail, !coreEvt.eraseFail};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      era_q     <= '0;
      eraBusy_q <= 1'b0;
      eraStat_q <= 2'b00;
    end else begin
      era_q     <= era_d;
      eraBusy_q <= eraBusy_d;
      eraStat_q <= eraStat_d;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------------------
  logic [7:0]        flag_q,    flag_d;
  logic [7:0]        evtVec;
  logic [7:0]        clrVec;
  logic              irq_q,     irq_d;

  always_comb begin
    evtVec = 8'h00;
    evtVec[IRQ_PGM_ERR]     = coreEvt.pgmErr;
    evtVec[IRQ_BENCH]       = coreEvt.bench;
    evtVec[IRQ_ERASE_DONE]  = coreEvt.eraseDone || coreEvt.eraseFail;
    evtVec[IRQ_BURST_PGM]   = coreEvt.burstPgmDone;
    evtVec[IRQ_WORD_PGM]    = coreEvt.wordPgmDone;
    evtVec[IRQ_POST_VFY]    = coreEvt.postVerifyFail;
    evtVec[IRQ_PRE_VFY]     = coreEvt.preVerifyFail;
    evtVec[IRQ_BURST_RDCMP] = coreEvt.burstRdCmpDone;
    clrVec = 8'h00;
    if (wrAcc && hit(paddr, ADDR_IRQCLR)) begin
      clrVec = pwdata[7:0];
    end
    // read clears only the flags it returned
    if (rdAcc && hit(paddr, ADDR_IRQRAW)) begin
      clrVec = rd_q[7:0];
    end
    // set wins over a same-cycle clear
    flag_d = (flag_q & ~clrVec) | evtVec;
    irq_d  = |(flag_d & irqEn_d);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 8'h00;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q  <= irq_d;
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  logic [31:0]       rd_q,      rd_d;
  logic              err_q,     err_d;

  // captured in setup, stands through access
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    if (psel && !penable) begin
      err_d = !mapped;
      if (!pwrite) begin
        unique case (1'b1)
          hit(paddr, ADDR_BUFCTL):  rd_d = {28'h0, bufEn_q};
          hit(paddr, ADDR_PGMCTL):  rd_d = {30'h0, wMode_q, pgmEn_q};
          hit(paddr, ADDR_PGMADDR): rd_d = pgmAddr_q;
          hit(paddr, ADDR_ERASTAT): rd_d = {29'h0, eraStat_q, eraBusy_q};
          hit(paddr, ADDR_IRQRAW):  rd_d = {24'h0, flag_q};
          hit(paddr, ADDR_IRQEN):   rd_d = {24'h0, irqEn_q};
          hit(paddr, ADDR_IRQMSK):  rd_d = {24'h0, flag_q & irqEn_q};
          hit(paddr, ADDR_OPSTAT):  rd_d = {29'h0, collCnt_q, coreBusy};
          default:                  rd_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q  <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rd_q  <= rd_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  assign prdata    = rd_q;
  assign pslverr   = err_q;
  // zero wait states
  assign pready    = 1'b1;
  assign pgmReq    = pgm_q;
  assign eraseReq  = era_q;
  assign readBufEn = bufEn_q;
  assign irq       = irq_q;

endmodule

// *** test/fcb_core_model.sv ***
`timescale 1ns/100ps
module fcb_core_model
  import fcb_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // requests and bench control
  input  wire fcb_pkg::fcb_pgm_req_t    pgmReq,
  input  wire fcb_pkg::fcb_erase_req_t  eraseReq,
  input  wire logic                     failNext,
  input  wire fcb_pkg::fcb_events_t     inject,
  // events back
  output fcb_pkg::fcb_events_t          coreEvt,
  output logic                          coreBusy
);
  logic [3:0] cnt_q;
  logic       era_q;
  logic       wide_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q   <= '0;
      era_q   <= 1'b0;
      wide_q  <= 1'b0;
      coreEvt <= '0;
    end else begin
      coreEvt <= inject;
      if (pgmReq.valid || eraseReq.valid) begin
        cnt_q  <= 4'hA;
        era_q  <= eraseReq.valid;
        wide_q <= pgmReq.wide;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          coreEvt.eraseDone    <= era_q && !failNext;
          coreEvt.eraseFail    <= era_q && failNext;
          coreEvt.wordPgmDone  <= !era_q && !wide_q;
          coreEvt.burstPgmDone <= !era_q && wide_q;
        end
      end
    end
  end
  assign coreBusy = cnt_q != 4'h0;
endmodule

// *** test/fcb_ctrl_chk.sv ***
`timescale 1ns/100ps
module fcb_ctrl_chk
  import fcb_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic                     clk,
  input wire logic                     rst,
  // apb
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [ADDR_W-1:0]        paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  // core side
  input wire fcb_pkg::fcb_pgm_req_t    pgmReq,
  input wire fcb_pkg::fcb_erase_req_t  eraseReq,
  input wire logic [3:0]               readBufEn,
  input wire fcb_pkg::fcb_events_t     coreEvt,
  input wire logic                     coreBusy,
  input wire logic                     irq
);
  logic       wr;
  logic [1:0] ctlQ;
  logic [7:0] enQ;
  logic [7:0] evt;
  assign wr  = psel && penable && pwrite;
  assign evt = {coreEvt.burstRdCmpDone, coreEvt.preVerifyFail, coreEvt.postVerifyFail, coreEvt.wordPgmDone,
                coreEvt.burstPgmDone, coreEvt.eraseDone | coreEvt.eraseFail, coreEvt.bench, coreEvt.pgmErr};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctlQ <= '0;
      enQ  <= '0;
    end else begin
      if (wr && paddr == ADDR_PGMCTL) ctlQ <= pwdata[1:0];
      if (wr && paddr == ADDR_IRQEN) enQ <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_wr(logic [11:0] a);
    wr && paddr == a;
  endsequence
  sequence s_quiet;
    evt == 8'h00 ##1 evt == 8'h00;
  endsequence
  property p_buf;
    s_wr(ADDR_BUFCTL) |=> readBufEn == $past(pwdata[3:0]);
  endproperty
  a_buf: assert property (p_buf) else $error("read buffer enables wrong");
  property p_off;
    s_wr(ADDR_PGMDATA) ##0 !ctlQ[0] |=> !pgmReq.valid;
  endproperty
  a_off: assert property (p_off) else $error("program started while disabled");
  property p_imm;
    s_wr(ADDR_PGMDATA) ##0 ctlQ == 2'b01 |=> pgmReq.valid && !pgmReq.wide && pgmReq.data[31:0] == $past(pwdata);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate program missing");
  property p_col;
    pgmReq.valid |-> $past(wr && paddr == ADDR_PGMDATA) && pgmReq.wide == ctlQ[1] &&
      (!pgmReq.wide || pgmReq.addr[3:0] == 4'h0);
  endproperty
  a_col: assert property (p_col) else $error("program request kind wrong");
  property p_era;
    eraseReq.valid |-> eraseReq.addr[11:0] == 12'h000 && eraseReq.info == $past(pwdata[1]) &&
      $past(wr && paddr == ADDR_ERACTL && pwdata[0]);
  endproperty
  a_era: assert property (p_era) else $error("erase request wrong");
  property p_mask;
    (evt & enQ) != 8'h00 && !(psel && penable) |=> irq;
  endproperty
  a_mask: assert property (p_mask) else $error("enabled event gave no interrupt");
  property p_dis;
    s_wr(ADDR_IRQEN) ##0 pwdata[7:0] == 8'h00 |-> ##2 !irq;
  endproperty
  a_dis: assert property (p_dis) else $error("interrupt with all sources off");
  property p_clr;
    s_wr(ADDR_IRQCLR) ##0 pwdata[7:0] == 8'hFF ##0 s_quiet |=> !irq;
  endproperty
  a_clr: assert property (p_clr) else $error("interrupt after full clear");
endmodule
bind fcb_ctrl fcb_ctrl_chk #(.ADDR_W(ADDR_W)) u_fcb_ctrl_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pgmReq(pgmReq), .eraseReq(eraseReq), .readBufEn(readBufEn), .coreEvt(coreEvt),
  .coreBusy(coreBusy), .irq(irq));

// *** test/flash_ctrl_buffer_program_erase_tb_top.sv ***
`timescale 1ns/100ps
module flash_ctrl_buffer_program_erase_tb_top;
  import fcb_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, coreBusy, failNext, err;
  logic [11:0]  paddr;
  logic [3:0]   readBufEn;
  logic [31:0]  pwdata, prdata, rd, a, d, m;
  logic [127:0] cd;
  fcb_pgm_req_t   pgmReq, lastPgm;
  fcb_erase_req_t eraseReq, lastEra;
  fcb_events_t    coreEvt, inject;
  int bad_count, n_tests, pgmN;
  fcb_ctrl u_fcb_ctrl (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pgmReq(pgmReq), .eraseReq(eraseReq),
    .readBufEn(readBufEn), .coreEvt(coreEvt), .coreBusy(coreBusy), .irq(irq));
  fcb_core_model u_fcb_core_model (.clk(clk), .rst(rst), .pgmReq(pgmReq), .eraseReq(eraseReq),
    .failNext(failNext), .inject(inject), .coreEvt(coreEvt), .coreBusy(coreBusy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pgmReq.valid === 1'b1) begin
      pgmN++;
      lastPgm = pgmReq;
    end
    if (eraseReq.valid === 1'b1) lastEra = eraseReq;
  end
  function automatic logic [31:0] sector(input logic [31:0] x);
    return {x[31:12], 12'h000};
  endfunction
  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task fire(input int b);
    @(posedge clk) inject <= fcb_events_t'(9'h1 << ((b < 3) ? 8 - b : 7 - b));
    @(posedge clk) inject <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    bad_count++;
    close_out();
  end
  initial begin
    {rst, psel, penable, pwrite, failNext} = 5'b10000;
    paddr = '0;
    pwdata = '0;
    inject = '0;
    void'($urandom(32'h9bdc0715));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(0, ADDR_BUFCTL, 0); chk("buffer reset", BUF_RESET, rd);
    chk("mapped error", 0, err);
    apb(0, 12'h0FC, 0); chk("unmapped error", 1, err);
    for (int i = 0; i < 6; i++) begin
      d = (i < 4) ? 32'h1 << i : $urandom;
      apb(1, ADDR_BUFCTL, d); chk("buffer enables", d[3:0], readBufEn);
    end
    apb(1, ADDR_PGMCTL, 0);
    apb(1, ADDR_PGMADDR, $urandom & 32'hFFFF_FFF0);
    apb(1, ADDR_PGMDATA, $urandom); tick(); chk("program while off", 0, pgmN);
    apb(1, ADDR_PGMCTL, 1);
    d = $urandom;
    apb(1, ADDR_PGMDATA, d); tick(); chk("immediate data", {1'b0, d}, {lastPgm.wide, lastPgm.data[31:0]});
    apb(1, ADDR_PGMCTL, 3);
    for (int j = 0; j < 4; j++) begin
      cd[32*j+:32] = $urandom;
      apb(1, ADDR_PGMDATA, cd[32*j+:32]); tick(); chk("collated count", (j < 3) ? 1 : 2, pgmN);
    end
    chk("collated data", {cd, 1'b1}, {lastPgm.data, lastPgm.wide});
    repeat (12) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      a = $urandom | 32'h0000_0123;
      failNext <= i[0];
      apb(1, ADDR_PGMADDR, a);
      apb(1, ADDR_ERACTL, {30'h0, i[0], 1'b1});
      apb(0, ADDR_ERASTAT, 0); chk("erase busy", 1, rd[0]);
      apb(0, ADDR_OPSTAT, 0); chk("core busy", 1, rd[0]);
      chk("erase sector", {sector(a), i[0]}, {lastEra.addr, lastEra.info});
      repeat (15) @(posedge clk);
      apb(0, ADDR_ERASTAT, 0); chk("erase outcome", i ? 3'b100 : 3'b010, rd[2:0]);
      apb(0, ADDR_IRQRAW, 0); chk("erase flag", 32'h4, rd & 32'h4);
    end
    apb(1, ADDR_IRQEN, 0);
    apb(1, ADDR_IRQCLR, 32'hFF);
    for (int b = 0; b < IRQ_NUM; b++) begin
      m = 32'h1 << b;
      fire(b); chk("irq while off", 0, irq);
      apb(0, ADDR_IRQMSK, 0); chk("masked off", 0, rd);
      apb(1, ADDR_IRQEN, ($urandom | m) & 32'hFF); tick(); chk("irq late enable", 1, irq);
      apb(0, ADDR_IRQMSK, 0); chk("masked on", m, rd);
      apb(1, ADDR_IRQCLR, m); tick(); chk("irq cleared", 0, irq);
      fire(b); chk("irq enabled", 1, irq);
      apb(0, ADDR_IRQRAW, 0); chk("raw view", m, rd);
      tick(); chk("irq after raw read", 0, irq);
      apb(1, ADDR_IRQEN, 0);
    end
    close_out();
  end
endmodule
